// *** fcrc_top.v ***
// flash and general checksum units with their peripheral registers
//
// Contract
// R01: while cpu halted, fetch one 32-bit flash word per clock and fold it
// R02: fast engine uses polynomial x^16 + x^12 + x^5 + 1
// R03: fast engine folds each word from bit 31 down to bit 0
// R04: enable set starts the check on halt; software halts from ram
// R05: 3-bit range picks span from zero, 16 K steps, minus 4 bytes
// R06: software keeps the expected value in the 4 bytes left out
// R07: fast result register writable only while fast engine enabled
// R08: fast engine reads code flash only
// R09: general engine works on main or subsystem clock alike
// R10: in halt, only dma-delivered bytes feed the general engine
// R11: general engine reverses each byte and uses the same polynomial
// R12: input register is 8 bits; every write is a new byte
// R13: running result stored one clock after each input write
// R14: running result writable by 16-bit access, any value
// R15: software write to running result lost if a result is stored then
// R16: software reads running result before writing the next byte
// R17: each new byte folds onto the current running result
// R18: after the last word, result kept and cpu released from halt
`include "fcrc_regs.vh"

module fcrc_top (
  // clock and reset
  input  wire                       clock,
  input  wire                       rstn,
  // peripheral register port
  input  wire [`FCRC_ADDR_W-1:0]    sfr_addr,
  input  wire [15:0]                sfr_wdata,
  input  wire                       sfr_we,
  input  wire                       sfr_re,
  input  wire                       sfr_word,
  input  wire                       sfr_dma,
  output wire [15:0]                sfr_rdata,
  output wire                       sfr_hit,
  // cpu status
  input  wire                       cpu_halted,
  input  wire                       halt_exec,
  output wire                       hs_busy,
  output wire                       hs_wake,
  // code flash read port
  output wire                       flash_rd,
  output wire [`FCRC_FADDR_W-1:0]   flash_addr,
  input  wire [31:0]                flash_rdata
);

  // register state
  reg  [7:0]   ctl_ff;
  reg  [15:0]  hs_res_ff;
  reg  [15:0]  nxt_hs_res;
  reg  [15:0]  gp_res_ff;
  reg  [15:0]  nxt_gp_res;
  reg  [15:0]  rdata_ff;
  reg  [15:0]  nxt_rdata;
  reg          hit_ff;

  // decode
  wire         sel_ctl;
  wire         sel_hsres;
  wire         sel_gpin;
  wire         sel_gpres;
  wire         any_sel;
  wire         wr_ctl;
  wire         wr_hsres;
  wire         wr_gpin;
  wire         wr_gpres;
  wire         gpin_src_ok;

  // engine links
  wire         hs_en;
  wire [2:0]   hs_range;
  wire         hs_start;
  wire         hs_word_valid;
  wire         hs_eng_busy;
  wire         hs_eng_done;
  wire [7:0]   gp_byte_q;
  wire [7:0]   gp_byte_rev;
  wire         gp_fold_valid;
  wire [15:0]  gp_res_rev;
  wire [15:0]  gp_fold_msb;
  wire [15:0]  gp_fold_lsb;

  // bit-serial fold, msb of data first; the loop is fixed at 32 steps
  // so one function serves both the word and the byte engine
  function [15:0] crc_fold;
    input [15:0] crc;
    input [31:0] data;
    input [5:0]  nbits;
    integer      i;
    reg   [15:0] c;
    reg          fb;
    begin
      c  = crc;
      fb = 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        if (i < nbits) begin
          fb = c[15] ^ data[31-i]; // R03
          c  = {c[14:0], 1'b0};
          if (fb) begin
            c = c ^ `FCRC_POLY; // R02
          end
        end
      end
      crc_fold = c;
    end
  endfunction

  // address decode; access width must match the register
  assign sel_ctl   = (sfr_addr == `FCRC_CTL_ADDR)   && !sfr_word;
  assign sel_hsres = (sfr_addr == `FCRC_HSRES_ADDR) &&  sfr_word;
  assign sel_gpin  = (sfr_addr == `FCRC_GPIN_ADDR)  && !sfr_word;
  assign sel_gpres = (sfr_addr == `FCRC_GPRES_ADDR) &&  sfr_word; // R14
  assign any_sel   = sel_ctl | sel_hsres | sel_gpin | sel_gpres;

  // cpu is stopped during halt, so only dma can deliver bytes then
  assign gpin_src_ok = !cpu_halted || sfr_dma; // R10

  assign wr_ctl    = sfr_we && sel_ctl && !hs_eng_busy;
  assign wr_hsres  = sfr_we && sel_hsres && hs_en && !hs_eng_busy; // R07
  assign wr_gpin   = sfr_we && sel_gpin && gpin_src_ok; // R12
  assign wr_gpres  = sfr_we && sel_gpres;

  // control register
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl_ff <= `FCRC_CTL_RST;
    end else if (wr_ctl) begin
      ctl_ff <= sfr_wdata[7:0] & `FCRC_CTL_MASK;
    end
  end

  assign hs_en    = ctl_ff[`FCRC_CTL_EN_BIT];
  assign hs_range = ctl_ff[`FCRC_CTL_RNG_MSB:`FCRC_CTL_RNG_LSB]; // R05

  // the check only starts on the halt instruction with the enable set
  assign hs_start = halt_exec && hs_en && !hs_eng_busy; // R04

  fcrc_hs_engine u_hs (
    .clock      (clock),
    .rstn       (rstn),
    .start      (hs_start),
    .range_sel  (hs_range),
    .flash_rd   (flash_rd),
    .flash_addr (flash_addr),
    .word_valid (hs_word_valid),
    .busy       (hs_eng_busy),
    .done       (hs_eng_done)
  );

  // fast result: folds every returned flash word, seeded by its content
  always @* begin
    nxt_hs_res = hs_res_ff;
    if (hs_word_valid) begin
      nxt_hs_res = crc_fold(hs_res_ff, flash_rdata, 6'd32); // R01
    end else if (wr_hsres) begin
      nxt_hs_res = sfr_wdata;
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hs_res_ff <= `FCRC_HSRES_RST;
    end else begin
      hs_res_ff <= nxt_hs_res;
    end
  end

  // wake once the final word is in; result simply stays put
  assign hs_busy = hs_eng_busy;
  assign hs_wake = hs_eng_done; // R18

  // general engine runs off the single peripheral clock, whichever
  // source feeds it, so no clock-mode logic is needed here
  fcrc_gp_engine u_gp (
    .clock      (clock),
    .rstn       (rstn),
    .load       (wr_gpin),
    .byte_in    (sfr_wdata[7:0]),
    .byte_q     (gp_byte_q),
    .byte_rev   (gp_byte_rev),
    .fold_valid (gp_fold_valid)
  ); // R09

  // running result is kept lsb first: the msb-first fold works on its
  // mirror image and the sum is mirrored back before it is stored
  genvar m;
  generate
    for (m = 0; m < 16; m = m + 1) begin : g_mirror
      assign gp_res_rev[m]  = gp_res_ff[15-m]; // R11
      assign gp_fold_lsb[m] = gp_fold_msb[15-m];
    end
  endgenerate

  assign gp_fold_msb = crc_fold(gp_res_rev, {gp_byte_rev, 24'h000000},
                                6'h08); // R11

  // running result; engine store beats a software write that clock
  always @* begin
    nxt_gp_res = gp_res_ff;
    if (gp_fold_valid) begin
      nxt_gp_res = gp_fold_lsb; // R17
    end else if (wr_gpres) begin
      nxt_gp_res = sfr_wdata; // R15
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gp_res_ff <= `FCRC_GPRES_RST;
    end else begin
      gp_res_ff <= nxt_gp_res; // R13
    end
  end

  // registered read data, unmapped addresses return zero
  always @* begin
    nxt_rdata = rdata_ff;
    if (sfr_re) begin
      nxt_rdata = 16'h0000;
      if (sel_ctl) begin
        nxt_rdata = {8'h00, ctl_ff};
      end
      if (sel_hsres) begin
        nxt_rdata = hs_res_ff;
      end
      if (sel_gpin) begin
        nxt_rdata = {8'h00, gp_byte_q};
      end
      if (sel_gpres) begin
        nxt_rdata = gp_res_ff;
      end
    end
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 16'h0000;
      hit_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      hit_ff   <= (sfr_re || sfr_we) && any_sel;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign sfr_hit   = hit_ff;

endmodule // fcrc_top

// *** fcrc_regs.vh ***
// register map, field positions and constants of the checksum units
`ifndef FCRC_REGS_VH
`define FCRC_REGS_VH

// peripheral register addresses (20-bit address space)
`define FCRC_ADDR_W        20
`define FCRC_CTL_ADDR      20'hf02f0
`define FCRC_HSRES_ADDR    20'hf02f2
`define FCRC_GPIN_ADDR     20'hfffac
`define FCRC_GPRES_ADDR    20'hfffae

// fields of flash_check_control
`define FCRC_CTL_EN_BIT    7
`define FCRC_CTL_RNG_MSB   2
`define FCRC_CTL_RNG_LSB   0
`define FCRC_CTL_MASK      8'h87

// reset values
`define FCRC_CTL_RST       8'h00
`define FCRC_HSRES_RST     16'h0000
`define FCRC_GPIN_RST      8'h00
`define FCRC_GPRES_RST     16'h0000

// checksum polynomial x^16 + x^12 + x^5 + 1
`define FCRC_POLY          16'h1021

// flash geometry: 32-bit words, 16 KB steps
`define FCRC_WIDX_W        15
`define FCRC_FADDR_W       17
`define FCRC_LAST_OFS      16'h0ffe

// timing: result stored one clock after an input byte write
`define FCRC_CLK_NS        10
`define FCRC_GP_LAT        1

`endif

// *** fcrc_hs_engine.v ***
// fast flash checksum sequencer: one 32-bit flash word per clock
`include "fcrc_regs.vh"

module fcrc_hs_engine (
  // clock and reset
  input  wire                       clock,
  input  wire                       rstn,
  // control
  input  wire                       start,
  input  wire [2:0]                 range_sel,
  // flash read port, data valid the clock after the request
  output wire                       flash_rd,
  output wire [`FCRC_FADDR_W-1:0]   flash_addr,
  // word stream and status
  output wire                       word_valid,
  output wire                       busy,
  output wire                       done
);

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_FETCH = 2'd1;
  localparam [1:0] ST_DRAIN = 2'd2;

  reg  [1:0]               state_ff;
  reg  [1:0]               nxt_state;
  reg  [`FCRC_WIDX_W-1:0]  idx_ff;
  reg  [`FCRC_WIDX_W-1:0]  nxt_idx;
  reg                      rd_ff;
  reg                      nxt_rd;
  reg                      rdd_ff;
  reg                      done_ff;
  reg                      nxt_done;
  reg  [2:0]               rng_ff;
  wire [15:0]              last16;
  wire [`FCRC_WIDX_W-1:0]  last_idx;

  // span ends 4 bytes short of each 16 KB boundary
  assign last16   = {1'b0, rng_ff, 12'h000} + `FCRC_LAST_OFS; // R05
  assign last_idx = last16[`FCRC_WIDX_W-1:0];

  always @* begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_rd    = 1'b0;
    nxt_done  = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_FETCH;
          nxt_idx   = {`FCRC_WIDX_W{1'b0}};
          nxt_rd    = 1'b1;
        end
      end
      ST_FETCH: begin
        if (idx_ff == last_idx) begin
          nxt_state = ST_DRAIN;
        end else begin
          nxt_idx = idx_ff + 1'b1; // R01
          nxt_rd  = 1'b1;
        end
      end
      ST_DRAIN: begin
        // last word arrives now; release the cpu next clock
        nxt_state = ST_IDLE;
        nxt_done  = 1'b1; // R18
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      idx_ff   <= {`FCRC_WIDX_W{1'b0}};
      rd_ff    <= 1'b0;
      rdd_ff   <= 1'b0;
      done_ff  <= 1'b0;
      rng_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      rd_ff    <= nxt_rd;
      rdd_ff   <= rd_ff;
      done_ff  <= nxt_done;
      if (start && state_ff == ST_IDLE) begin
        rng_ff <= range_sel;
      end
    end
  end

  // only flash word addresses are ever generated
  assign flash_rd   = rd_ff; // R08
  assign flash_addr = {idx_ff, 2'b00};
  assign word_valid = rdd_ff;
  assign busy       = (state_ff != ST_IDLE) || done_ff;
  assign done       = done_ff;

endmodule // fcrc_hs_engine

// *** fcrc_gp_engine.v ***
// general checksum input stage: byte latch and bit reversal
`include "fcrc_regs.vh"

module fcrc_gp_engine (
  // clock and reset
  input  wire        clock,
  input  wire        rstn,
  // accepted byte write
  input  wire        load,
  input  wire [7:0]  byte_in,
  // latched byte and its reversed image
  output wire [7:0]  byte_q,
  output wire [7:0]  byte_rev,
  output wire        fold_valid
);

  reg [7:0] byte_ff;
  reg       pend_ff;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      byte_ff <= `FCRC_GPIN_RST;
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= load; // R13
      if (load) begin
        byte_ff <= byte_in; // R12
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_rev
      assign byte_rev[g] = byte_ff[7-g]; // R11
    end
  endgenerate

  assign byte_q     = byte_ff;
  assign fold_valid = pend_ff;

endmodule // fcrc_gp_engine

// *** fcrc_chk_sva.sv ***
// assertion checker on the checksum unit ports
`include "fcrc_regs.vh"
module fcrc_chk (
  // watched ports
  input wire        clock,
  input wire        rstn,
  input wire [19:0] sfr_addr,
  input wire [15:0] sfr_wdata,
  input wire        sfr_we,
  input wire        sfr_re,
  input wire        sfr_word,
  input wire        sfr_hit,
  input wire        cpu_halted,
  input wire        halt_exec,
  input wire        hs_busy,
  input wire        hs_wake,
  input wire        flash_rd,
  input wire [16:0] flash_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // control shadow; the unit ignores control writes while busy
  logic        en_ff;
  logic [2:0]  rng_ff;
  wire  [16:0] last_w = {rng_ff, 14'h0} + 17'h3ff8;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_ff <= 1'b0;
      rng_ff <= 3'h0;
    end else if (sfr_we && !sfr_word && !hs_busy &&
                 sfr_addr == `FCRC_CTL_ADDR) begin
      en_ff <= sfr_wdata[7];
      rng_ff <= sfr_wdata[2:0];
    end
  end
  fast_start_a: assert property (
    halt_exec && en_ff && !hs_busy |=> flash_rd && hs_busy)
    else $error("check did not start on halt");
  fast_idle_a: assert property (
    halt_exec && !en_ff && !hs_busy |=> !hs_busy [*2])
    else $error("check started while disabled");
  first_word_a: assert property (
    $rose(flash_rd) |-> flash_addr == 17'h0)
    else $error("first word not at zero");
  word_step_a: assert property (
    flash_rd && $past(flash_rd) |-> flash_addr == $past(flash_addr) + 17'h4)
    else $error("word address did not step by four");
  last_word_a: assert property (
    $fell(flash_rd) |-> $past(flash_addr) == last_w)
    else $error("last word address wrong");
  wake_after_a: assert property (
    $fell(flash_rd) |=> hs_wake)
    else $error("no wake after last word");
  wake_pulse_a: assert property (
    hs_wake |-> hs_busy ##1 (!hs_wake && !hs_busy))
    else $error("wake not a single busy-ending pulse");
  halted_fetch_a: assert property (
    flash_rd |-> cpu_halted)
    else $error("flash fetched while cpu running");
  byte_hit_a: assert property (
    sfr_we && !sfr_word && sfr_addr == `FCRC_GPIN_ADDR |=> sfr_hit)
    else $error("byte input write not taken");
endmodule // fcrc_chk

// *** fcrc_flash_model.sv ***
// code flash model: one 32-bit word a clock after each request
module fcrc_flash_model (
  // flash read port
  input  wire         clock,
  input  wire [16:0]  flash_addr,
  input  wire         flash_rd,
  output logic [31:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  function automatic [31:0] word_at(input [16:0] a);
    word_at = {a[15:0] ^ 16'hc35a, ~a[16:1]};
  endfunction
  initial flash_rdata = 32'h0f0f0f0f;
  // idle bus toggles so stale data never passes for a fresh word
  always @(posedge clock) begin
    if (flash_rd)
      flash_rdata <= word_at(flash_addr);
    else
      flash_rdata <= ~flash_rdata;
  end
endmodule // fcrc_flash_model

// *** testbench.sv ***
// self-checking bench for the checksum unit
`include "fcrc_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [19:0] sfr_addr = 20'h0;
  logic [15:0] sfr_wdata = 16'h0;
  logic        sfr_we = 1'b0;
  logic        sfr_re = 1'b0;
  logic        sfr_word = 1'b0;
  logic        sfr_dma = 1'b0;
  logic        cpu_halted = 1'b0;
  logic        halt_exec = 1'b0;
  wire  [15:0] sfr_rdata;
  wire         sfr_hit;
  wire         hs_busy;
  wire         hs_wake;
  wire         flash_rd;
  wire  [16:0] flash_addr;
  wire  [31:0] flash_rdata;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;
  logic [15:0] crc;
  initial forever #5 clock = ~clock;
  fcrc_top i_fcrc_top (.clock(clock), .rstn(rstn), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_word(sfr_word), .sfr_dma(sfr_dma), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .cpu_halted(cpu_halted), .halt_exec(halt_exec),
    .hs_busy(hs_busy), .hs_wake(hs_wake), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata));
  fcrc_flash_model i_fcrc_flash_model (.clock(clock),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata));
  function automatic [15:0] fold(input [15:0] c, input [31:0] d, input int k);
    for (int i = k - 1; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `FCRC_POLY : 16'h0);
    return c;
  endfunction
  function automatic [15:0] gp(input [15:0] c, input [7:0] b);
    logic [7:0]  r;
    logic [15:0] s;
    for (int i = 0; i < 8; i++)
      r[i] = b[7-i];
    // result register holds the lsb-first image of the msb-first state
    for (int i = 0; i < 16; i++)
      s[i] = c[15-i];
    s = fold(s, {24'h0, r}, 8);
    for (int i = 0; i < 16; i++)
      c[i] = s[15-i];
    return c;
  endfunction
  task automatic chk(input string nm, input [15:0] e, input [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input [19:0] a, input [15:0] d, input w, input dm);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_word = w;
    sfr_dma = dm;
    sfr_we = 1'b1;
    @(negedge clock);
    sfr_we = 1'b0;
  endtask
  task automatic rdc(input string nm, input [19:0] a, input w, input [15:0] e);
    @(negedge clock);
    sfr_addr = a;
    sfr_word = w;
    sfr_re = 1'b1;
    @(negedge clock);
    sfr_re = 1'b0;
    chk(nm, e, sfr_rdata);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic run_fast(input [2:0] r);
    wr(`FCRC_CTL_ADDR, {8'h0, 5'h10, r}, 1'b0, 1'b0);
    wr(`FCRC_HSRES_ADDR, 16'h0, 1'b1, 1'b0);
    crc = 16'h0;
    for (int a = 0; a < (r + 1) * 16384 - 4; a += 4)
      crc = fold(crc, i_fcrc_flash_model.word_at(a[16:0]), 32);
    @(negedge clock);
    cpu_halted = 1'b1;
    halt_exec = 1'b1;
    @(negedge clock);
    halt_exec = 1'b0;
    n = 0;
    // bounded wait, long enough for the largest span
    while (hs_wake !== 1'b1 && n < 40000) begin
      @(negedge clock);
      n++;
    end
    if (n == 40000) begin
      err_count++;
      finish_test();
    end
    cpu_halted = 1'b0;
    rdc("fast result", `FCRC_HSRES_ADDR, 1'b1, crc);
    $display("fast check range %0d done", r);
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    rdc("control", `FCRC_CTL_ADDR, 1'b0, 16'h0);
    rdc("fast result", `FCRC_HSRES_ADDR, 1'b1, 16'h0);
    rdc("byte input", `FCRC_GPIN_ADDR, 1'b0, 16'h0);
    rdc("running result", `FCRC_GPRES_ADDR, 1'b1, 16'h0);
    wr(`FCRC_HSRES_ADDR, 16'hbeef, 1'b1, 1'b0);
    rdc("fast result", `FCRC_HSRES_ADDR, 1'b1, 16'h0);
    wr(`FCRC_CTL_ADDR, 16'h00ff, 1'b0, 1'b0);
    rdc("control", `FCRC_CTL_ADDR, 1'b0, 16'h0087);
    wr(`FCRC_HSRES_ADDR, 16'hbeef, 1'b1, 1'b0);
    rdc("fast result", `FCRC_HSRES_ADDR, 1'b1, 16'hbeef);
    wr(`FCRC_CTL_ADDR, 16'h0, 1'b0, 1'b0);
    @(negedge clock);
    halt_exec = 1'b1;
    @(negedge clock);
    halt_exec = 1'b0;
    chk("busy", 16'h0, {15'h0, hs_busy});
    $display("register test done");
    crc = 16'h0;
    for (int i = 0; i < 4; i++) begin
      wr(`FCRC_GPIN_ADDR, {8'h0, 8'h78 - 8'h22 * i[7:0]}, 1'b0, 1'b0);
      crc = gp(crc, 8'h78 - 8'h22 * i[7:0]);
      rdc("running result", `FCRC_GPRES_ADDR, 1'b1, crc);
    end
    rdc("running result", `FCRC_GPRES_ADDR, 1'b1, 16'h08f6);
    wr(`FCRC_GPRES_ADDR, 16'hffff, 1'b1, 1'b0);
    rdc("running result", `FCRC_GPRES_ADDR, 1'b1, 16'hffff);
    // byte write then a colliding result write one cycle later
    @(negedge clock);
    sfr_addr = `FCRC_GPIN_ADDR;
    sfr_wdata = 16'h00a5;
    sfr_word = 1'b0;
    sfr_we = 1'b1;
    @(negedge clock);
    sfr_addr = `FCRC_GPRES_ADDR;
    sfr_wdata = 16'h1234;
    sfr_word = 1'b1;
    @(negedge clock);
    sfr_we = 1'b0;
    rdc("running result", `FCRC_GPRES_ADDR, 1'b1, gp(16'hffff, 8'ha5));
    wr(`FCRC_GPRES_ADDR, 16'h0, 1'b1, 1'b0);
    cpu_halted = 1'b1;
    wr(`FCRC_GPIN_ADDR, 16'h003c, 1'b0, 1'b0);
    rdc("running result", `FCRC_GPRES_ADDR, 1'b1, 16'h0);
    wr(`FCRC_GPIN_ADDR, 16'h003c, 1'b0, 1'b1);
    rdc("running result", `FCRC_GPRES_ADDR, 1'b1, gp(16'h0, 8'h3c));
    cpu_halted = 1'b0;
    $display("general checksum test done");
    run_fast(3'h0);
    run_fast(3'h7);
    finish_test();
  end
endmodule // testbench
bind fcrc_top fcrc_chk i_fcrc_chk (.clock(clock), .rstn(rstn),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
  .sfr_re(sfr_re), .sfr_word(sfr_word), .sfr_hit(sfr_hit),
  .cpu_halted(cpu_halted), .halt_exec(halt_exec), .hs_busy(hs_busy),
  .hs_wake(hs_wake), .flash_rd(flash_rd), .flash_addr(flash_addr));
